/* File: hdl/reset_flags_and_interrupt_unit.sv */
/*
  Reset-cause flags, interrupt flags, masks, priority and the entry
  and return sequencing handed to the processor core.
  Assumes an APB master, a core that pulses instrDone at each
  instruction boundary and retiStart when it decodes a return, and
  synchronous pin and event inputs on clk_sys.
*/
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "irq_unit_defs.svh"

module reset_flags_and_interrupt_unit
  import irq_unit_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int ENTRY_CYC = `ENTRY_CYCLES,
  parameter int JUMP_CYC = `JUMP_CYCLES,
  parameter int RET_CYC = `RETURN_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Reset causes, sampled while rst_b is low
  input wire logic porReset,
  input wire logic extReset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Event sources
  input wire logic extPin,
  input wire logic ovfEvent,
  // Core sequencer
  input wire logic instrDone,
  input wire logic retiStart,
  output logic entryBusy,
  output logic vecValid,
  output logic [1:0] vecAddr,
  output logic retBusy,
  output logic globalEnable
);

  // ********************************
  // Elaboration checks
  // ********************************
  initial begin
    if (ADDR_W < 8 || ENTRY_CYC < 1 || ENTRY_CYC > 7 || JUMP_CYC < 1 ||
        JUMP_CYC > 7 || RET_CYC < 1 || RET_CYC > 7) begin
      $error("reset_flags_and_interrupt_unit: bad parameter");
    end
  end

  state_t state_reg;
  state_t state_next;
  logic extReq;
  logic extTrig;
  logic levelMode;
  logic access;
  logic wrDone;
  logic extClr;
  logic ovfClr;
  logic [7:0] offs;
  logic inMap;

  // Read value of one register, reserved bits zero
  function automatic logic [7:0] readReg(input state_t s,
                                         input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `OFS_RESET_CAUSE: begin
        v[`BIT_POWER_ON] = s.porSeen;
        v[`BIT_PIN_RESET] = s.pinSeen;
      end
      `OFS_EXT_MASK: v[`BIT_EXT_IRQ] = s.extEn;
      `OFS_EXT_FLAGS: v[`BIT_EXT_IRQ] = s.extPend;
      `OFS_TIMER_MASK: v[`BIT_OVF_IRQ] = s.ovfEn;
      `OFS_TIMER_FLAGS: v[`BIT_OVF_IRQ] = s.ovfPend;
      `OFS_IRQ_CTRL: begin
        v[`BIT_GIE] = s.gie;
        v[`BIT_SENSE_LO] = s.sense[0];
        v[`BIT_SENSE_HI] = s.sense[1];
      end
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // Is an offset one of ours
  function automatic logic isMapped(input logic [7:0] a);
    return a == `OFS_RESET_CAUSE || a == `OFS_EXT_MASK ||
           a == `OFS_EXT_FLAGS || a == `OFS_TIMER_MASK ||
           a == `OFS_TIMER_FLAGS || a == `OFS_IRQ_CTRL;
  endfunction

  // ********************************
  // Next state
  // ********************************
  always_comb begin
    state_next = state_reg;
    offs = paddr[7:0];
    inMap = isMapped(offs) && ((paddr >> 8) == '0);
    access = psel && penable;
    wrDone = access && state_reg.pready && pwrite;
    state_next.vecValid = 1'b0;
    state_next.pready = 1'b0;
    state_next.pslverr = 1'b0;
    // One wait state, read data and error latched with pready
    if (access && !state_reg.pready) begin
      state_next.pready = 1'b1;
      state_next.pslverr = !inMap;
      state_next.prdata = {24'h000000, readReg(state_reg, offs)};
    end
    // Pin is sampled as a pad value whatever its direction
    state_next.pinPrev = extPin;
    levelMode = state_reg.sense == `SENSE_LOW;
    extTrig = (state_reg.sense == `SENSE_FALL && state_reg.pinPrev &&
               !extPin) ||
              (state_reg.sense == `SENSE_RISE && !state_reg.pinPrev &&
               extPin);
    extReq = levelMode ? !extPin : state_reg.extPend;
    extClr = 1'b0;
    ovfClr = 1'b0;
    // Register writes; interrupt flags clear on one only, cause flags take the written value
    if (wrDone && inMap) begin
      case (offs)
        `OFS_RESET_CAUSE: begin
          state_next.porSeen = pwdata[`BIT_POWER_ON];
          state_next.pinSeen = pwdata[`BIT_PIN_RESET];
        end
        `OFS_EXT_MASK: state_next.extEn = pwdata[`BIT_EXT_IRQ];
        `OFS_EXT_FLAGS: extClr = pwdata[`BIT_EXT_IRQ];
        `OFS_TIMER_MASK: state_next.ovfEn = pwdata[`BIT_OVF_IRQ];
        `OFS_TIMER_FLAGS: ovfClr = pwdata[`BIT_OVF_IRQ];
        `OFS_IRQ_CTRL: begin
          state_next.gie = pwdata[`BIT_GIE];
          state_next.sense = {pwdata[`BIT_SENSE_HI],
                              pwdata[`BIT_SENSE_LO]};
        end
        default: state_next.gie = state_reg.gie;
      endcase
    end
    // ********************************
    // Entry and return sequencing
    // ********************************
    // Status word is never pushed or popped here
    case (state_reg.seq)
      ST_RUN: begin
        if (retiStart) begin
          state_next.gie = 1'b1;
          state_next.seq = ST_RET;
          state_next.cnt = 3'(RET_CYC);
        end else if (instrDone && state_reg.gie &&
                     ((extReq && state_reg.extEn) ||
                      (state_reg.ovfPend && state_reg.ovfEn))) begin
          // Only at a boundary, so a long instruction finishes first
          state_next.gie = 1'b0;
          state_next.seq = ST_ENTRY;
          state_next.cnt = 3'(ENTRY_CYC);
          state_next.vecSel = (extReq && state_reg.extEn) ?
                              `VEC_EXT : `VEC_TIMER;
        end
      end
      ST_ENTRY: begin
        state_next.cnt = state_reg.cnt - 3'h1;
        if (state_reg.cnt == 3'h1) begin
          state_next.vecValid = 1'b1;
          state_next.vecAddr = state_reg.vecSel;
          state_next.seq = ST_JUMP;
          state_next.cnt = 3'(JUMP_CYC);
          if (state_reg.vecSel == `VEC_EXT) begin
            extClr = 1'b1;
          end else begin
            ovfClr = 1'b1;
          end
        end
      end
      ST_JUMP: begin
        state_next.cnt = state_reg.cnt - 3'h1;
        if (state_reg.cnt == 3'h1) begin
          state_next.seq = ST_RUN;
        end
      end
      ST_RET: begin
        state_next.cnt = state_reg.cnt - 3'h1;
        if (state_reg.cnt == 3'h1) begin
          state_next.seq = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // One main-program instruction before any new entry
        if (instrDone) begin
          state_next.seq = ST_RUN;
        end
      end
      default: state_next.seq = ST_RUN;
    endcase
    // Flags: a set in the same cycle as a clear wins
    state_next.extPend = levelMode ? 1'b0 :
      (extTrig || (state_reg.extPend && !extClr));
    state_next.ovfPend = ovfEvent ||
      (state_reg.ovfPend && !ovfClr);
    state_next.entryBusy = state_next.seq == ST_ENTRY;
    state_next.retBusy = state_next.seq == ST_RET;
    state_next.gieOut = state_next.gie;
    // Synchronous reset; cause flags depend on which reset is held
    if (!rst_b) begin
      state_next = '0;
      state_next.seq = ST_RUN;
      state_next.pinPrev = extPin;
      state_next.porSeen = porReset || state_reg.porSeen;
      // Pin flag is cleared by power-on, set by external reset
      state_next.pinSeen = porReset ? 1'b0 :
        (extReset || state_reg.pinSeen);
    end
  end

  // ********************************
  // State register
  // ********************************
  always_ff @(posedge clk_sys) begin
    state_reg <= state_next;
  end

  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign entryBusy = state_reg.entryBusy;
  assign vecValid = state_reg.vecValid;
  assign vecAddr = state_reg.vecAddr;
  assign retBusy = state_reg.retBusy;
  assign globalEnable = state_reg.gieOut;

  // ********************************
  // Assertions
  // ********************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  a_reserved_zero: assert property (
    pready && !pslverr |-> prdata[31:8] == 24'h000000 &&
      (paddr[7:0] != `OFS_RESET_CAUSE || prdata[7:2] == 6'h00) &&
      ((paddr[7:0] != `OFS_EXT_MASK && paddr[7:0] != `OFS_EXT_FLAGS) ||
       (!prdata[7] && prdata[5:0] == 6'h00)) &&
      ((paddr[7:0] != `OFS_TIMER_MASK && paddr[7:0] != `OFS_TIMER_FLAGS) ||
       (prdata[7:2] == 6'h00 && !prdata[0])))
    else $error("reserved bits read nonzero");

  a_power_on_flag: assert property (
    $rose(rst_b) && $past(porReset) |-> state_reg.porSeen)
    else $error("power-on flag not set");

  a_pin_reset_flag: assert property (
    $rose(rst_b) && $past(extReset) && !$past(porReset)
      |-> state_reg.pinSeen)
    else $error("pin reset flag not set");

  a_gie_on_entry: assert property (
    $rose(entryBusy) |-> !globalEnable)
    else $error("global enable left set on entry");

  a_gie_on_return: assert property (
    $rose(retBusy) |-> globalEnable)
    else $error("global enable not set by return");

  a_vector_clears: assert property (
    vecValid && vecAddr == `VEC_TIMER
      |-> !state_reg.ovfPend || $past(ovfEvent))
    else $error("overflow flag kept after vector");

  a_pin_vec_clears: assert property (
    vecValid && vecAddr == `VEC_EXT
      |-> !state_reg.extPend || $past(extTrig))
    else $error("pin flag kept after vector");

  a_level_noflag: assert property (
    state_reg.sense == `SENSE_LOW |=> !state_reg.extPend)
    else $error("pin flag set in level mode");

  a_entry_timing: assert property (
    $rose(entryBusy) |-> entryBusy [*4] ##1 (vecValid && !entryBusy))
    else $error("entry not four cycles");

  a_return_length: assert property (
    $rose(retBusy) |-> retBusy [*4] ##1 !retBusy)
    else $error("return not four cycles");

  a_after_return: assert property (
    $fell(retBusy) |-> !entryBusy ##1 !entryBusy)
    else $error("entry right after return");

  a_ext_priority: assert property (
    state_reg.seq == ST_RUN && instrDone && !retiStart &&
      state_reg.gie && extReq && state_reg.extEn
      |=> state_reg.vecSel == `VEC_EXT)
    else $error("timer served before pin");

  c_ext_vector: cover property (vecValid && vecAddr == `VEC_EXT);
  c_timer_vector: cover property (vecValid && vecAddr == `VEC_TIMER);
  c_return: cover property ($fell(retBusy));
  c_both_pending: cover property (
    state_reg.extPend && state_reg.ovfPend && $rose(entryBusy));

endmodule
`default_nettype wire

/* File: include/irq_unit_defs.svh */
/*
  Offsets, field positions, encodings and cycle counts of the
  reset-flag and interrupt unit. Assumes byte addresses on APB.
*/
`ifndef IRQ_UNIT_DEFS_SVH
`define IRQ_UNIT_DEFS_SVH
// Register byte offsets
`define OFS_RESET_CAUSE 8'h00
`define OFS_EXT_MASK 8'h04
`define OFS_EXT_FLAGS 8'h08
`define OFS_TIMER_MASK 8'h0c
`define OFS_TIMER_FLAGS 8'h10
`define OFS_IRQ_CTRL 8'h14
// Field positions
`define BIT_POWER_ON 0
`define BIT_PIN_RESET 1
`define BIT_EXT_IRQ 6
`define BIT_OVF_IRQ 1
`define BIT_GIE 0
`define BIT_SENSE_LO 1
`define BIT_SENSE_HI 2
// External sense encodings
`define SENSE_LOW 2'h0
`define SENSE_RSVD 2'h1
`define SENSE_FALL 2'h2
`define SENSE_RISE 2'h3
// Vector addresses
`define VEC_EXT 2'h1
`define VEC_TIMER 2'h2
// Cycle counts
`define ENTRY_CYCLES 4
`define JUMP_CYCLES 2
`define RETURN_CYCLES 4
`endif

/* File: include/irq_unit_pkg.sv */
/*
  Types of the reset-flag and interrupt unit.
  Assumes nothing of its surroundings.
*/
package irq_unit_pkg;
  typedef enum logic [2:0] {
    ST_RUN, ST_ENTRY, ST_JUMP, ST_RET, ST_HOLD
  } seq_t;
  typedef struct packed {
    logic porSeen;
    logic pinSeen;
    logic extEn;
    logic ovfEn;
    logic extPend;
    logic ovfPend;
    logic gie;
    logic [1:0] sense;
    logic pinPrev;
    seq_t seq;
    logic [2:0] cnt;
    logic [1:0] vecSel;
    logic vecValid;
    logic [1:0] vecAddr;
    logic entryBusy;
    logic retBusy;
    logic gieOut;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_t;
endpackage

/* File: verification/core_model.sv */
/*
  Stand-in for the processor core: an instruction boundary every third
  cycle, and a return pulse one cycle after each request.
  Assumes the unit's busy outputs stall the core.
*/
`timescale 1ns/1ps
`default_nettype none
module core_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Unit side
  input wire logic entryBusy,
  input wire logic retBusy,
  input wire logic retiReq,
  output logic instrDone,
  output logic retiStart
);
  logic [1:0] phase;
  // Three-cycle instructions, so events land in mid-instruction
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      phase <= 2'h0;
      instrDone <= 1'b0;
      retiStart <= 1'b0;
    end else begin
      phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
      instrDone <= (phase == 2'h2) && !entryBusy && !retBusy;
      retiStart <= retiReq;
    end
  end
endmodule
`default_nettype wire

/* File: verification/reset_flags_and_interrupt_unit_test.sv */
/*
  Self-checking bench: APB tasks, reset causes, flags, priority, entry
  and return. Assumes the unit and the core stand-in on one clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "irq_unit_defs.svh"
module reset_flags_and_interrupt_unit_test;
  logic clk_sys = 1'b0;
  logic rst_b, porReset, extReset, psel, penable, pwrite, extPin;
  logic ovfEvent, retiReq, pready, pslverr, instrDone, retiStart;
  logic entryBusy, vecValid, retBusy, globalEnable, errVal;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdVal;
  logic [1:0] vecAddr;
  int nMismatch = 0;
  int checkCount = 0;

  always #2.5 clk_sys = ~clk_sys;

  reset_flags_and_interrupt_unit reset_flags_and_interrupt_unit_inst (
    .clk_sys, .rst_b, .porReset, .extReset, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .extPin, .ovfEvent,
    .instrDone, .retiStart, .entryBusy, .vecValid, .vecAddr, .retBusy,
    .globalEnable);
  core_model core_model_inst (.clk_sys, .rst_b, .entryBusy, .retBusy,
    .retiReq, .instrDone, .retiStart);

  // ****************
  // Tasks
  // ****************
  task test_done;
    if (nMismatch == 0 && checkCount > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checkCount++;
    if (g !== e) begin
      nMismatch++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // A wait that runs out ends the run at once
  task bound(input int i);
    if (i >= 100) begin
      nMismatch++;
      test_done;
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      i++;
    end while (pready !== 1'b1 && i < 100);
    bound(i);
    rdVal = prdata;
    errVal = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  task rd(input string n, input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, {24'h0, e}, rdVal);
  endtask

  task do_reset(input logic por, input logic ext);
    @(posedge clk_sys);
    rst_b <= 1'b0;
    porReset <= por;
    extReset <= ext;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    porReset <= 1'b0;
    extReset <= 1'b0;
  endtask

  task pin(input logic v);
    @(posedge clk_sys);
    extPin <= v;
    repeat (2) @(posedge clk_sys);
  endtask

  task ovf;
    @(posedge clk_sys);
    ovfEvent <= 1'b1;
    @(posedge clk_sys);
    ovfEvent <= 1'b0;
  endtask

  // Counts the cycles of entry seen before the vector pulse
  task wait_vec(input logic [1:0] e);
    int i;
    int n;
    i = 0;
    n = 0;
    while (vecValid !== 1'b1 && i < 100) begin
      @(posedge clk_sys);
      i++;
      if (entryBusy === 1'b1) n++;
    end
    bound(i);
    chk("vecAddr", {30'h0, e}, {30'h0, vecAddr});
    chk("globalEnable", 32'h0, {31'h0, globalEnable});
    chk("entryLength", `ENTRY_CYCLES, n);
  endtask

  task retire;
    int i;
    int n;
    i = 0;
    n = 1;
    @(posedge clk_sys);
    retiReq <= 1'b1;
    @(posedge clk_sys);
    retiReq <= 1'b0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (retBusy !== 1'b1 && i < 100);
    do begin
      @(posedge clk_sys);
      i++;
      if (retBusy === 1'b1) n++;
    end while (retBusy === 1'b1 && i < 100);
    bound(i);
    chk("globalEnable", 32'h1, {31'h0, globalEnable});
    chk("retLength", `RETURN_CYCLES, n);
  endtask

  // ****************
  // Sequence
  // ****************
  initial begin
    rst_b = 1'b0;
    porReset = 1'b0;
    extReset = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    extPin = 1'b1;
    ovfEvent = 1'b0;
    retiReq = 1'b0;
    do_reset(1'b1, 1'b0);
    rd("cause", `OFS_RESET_CAUSE, 8'h01);
    do_reset(1'b0, 1'b1);
    rd("cause", `OFS_RESET_CAUSE, 8'h03);
    do_reset(1'b0, 1'b0);
    rd("cause", `OFS_RESET_CAUSE, 8'h03);
    wr(`OFS_RESET_CAUSE, 8'h00);
    do_reset(1'b0, 1'b1);
    rd("cause", `OFS_RESET_CAUSE, 8'h02);
    wr(`OFS_RESET_CAUSE, 8'hff);
    rd("cause", `OFS_RESET_CAUSE, 8'h03);
    wr(`OFS_EXT_MASK, 8'hff);
    rd("extMask", `OFS_EXT_MASK, 8'h40);
    wr(`OFS_TIMER_MASK, 8'hff);
    rd("timerMask", `OFS_TIMER_MASK, 8'h02);
    apb(1'b0, 8'h18, 32'h0);
    chk("slverr", 32'h1, {31'h0, errVal});
    chk("unmapped", 32'h0, rdVal);
    ovf;
    rd("timerFlags", `OFS_TIMER_FLAGS, 8'h02);
    wr(`OFS_TIMER_FLAGS, 8'h00);
    rd("timerFlags", `OFS_TIMER_FLAGS, 8'h02);
    wr(`OFS_IRQ_CTRL, 8'h04);
    pin(1'b0);
    rd("extFlags", `OFS_EXT_FLAGS, 8'h40);
    wr(`OFS_IRQ_CTRL, 8'h05);
    wait_vec(`VEC_EXT);
    rd("extFlags", `OFS_EXT_FLAGS, 8'h00);
    rd("timerFlags", `OFS_TIMER_FLAGS, 8'h02);
    retire;
    wait_vec(`VEC_TIMER);
    rd("timerFlags", `OFS_TIMER_FLAGS, 8'h00);
    retire;
    wr(`OFS_IRQ_CTRL, 8'h06);
    pin(1'b1);
    rd("extFlags", `OFS_EXT_FLAGS, 8'h40);
    wr(`OFS_EXT_FLAGS, 8'h40);
    rd("extFlags", `OFS_EXT_FLAGS, 8'h00);
    wr(`OFS_IRQ_CTRL, 8'h02);
    pin(1'b0);
    pin(1'b1);
    rd("extFlags", `OFS_EXT_FLAGS, 8'h00);
    ovf;
    wr(`OFS_TIMER_FLAGS, 8'h02);
    rd("timerFlags", `OFS_TIMER_FLAGS, 8'h00);
    wr(`OFS_IRQ_CTRL, 8'h00);
    pin(1'b0);
    rd("extFlags", `OFS_EXT_FLAGS, 8'h00);
    wr(`OFS_IRQ_CTRL, 8'h01);
    wait_vec(`VEC_EXT);
    test_done;
  end
endmodule
`default_nettype wire
